// [verilog/cbu_pkg.sv]
/*
 * cbu_pkg: constants and types shared by the conditional branch unit.
 * assumes instruction words use big-endian bit numbering (bit 0 is the msb).
 */
package cbu_pkg;

	localparam int CBU_W = 32;
	// field positions, counted from the msb as the instruction set numbers them
	localparam int OPC_HI = 0;
	localparam int OPC_LO = 5;
	localparam int DLY_BIT = 6;
	localparam int COND_HI = 7;
	localparam int COND_LO = 10;
	localparam int CMP_REG_HI = 11;
	localparam int CMP_REG_LO = 15;
	localparam int OFS_REG_HI = 16;
	localparam int OFS_REG_LO = 20;
	localparam int IMM_HI = 16;
	localparam int IMM_LO = 31;

	localparam logic [5:0] OPC_REG = 6'h27;
	localparam logic [5:0] OPC_IMM = 6'h2f;
	localparam logic [3:0] COND_GT = 4'h4;
	localparam logic [3:0] COND_LE = 4'h3;
	localparam logic [3:0] COND_LT = 4'h2;
	localparam logic [31:0] PC_STEP = 32'h0000_0004;
	localparam logic [31:0] PC_RESET = 32'h0000_0000;

	// total cycles per outcome
	localparam int LAT_NOT_TAKEN = 1;
	localparam int LAT_TAKEN_DLY = 2;
	localparam int LAT_TAKEN_NODLY = 3;
	localparam int LAT_MISP_AREA0 = 3;
	localparam int LAT_MISP_AREA2 = 8;
	localparam logic [3:0] STALL_RESET = 4'h0;

	typedef enum logic [1:0] {
		CBU_CMP_GT,
		CBU_CMP_LE,
		CBU_CMP_LT,
		CBU_CMP_NONE
	} cbu_cmp_t;

endpackage

// [verilog/cbu_dec_if.sv]
/*
 * cbu_dec_if: decoded branch fields passed from decoder to the branch unit.
 * assumes one decoder and one consumer in the same clock domain.
 */
`timescale 1ns/10ps
interface cbu_dec_if;
	import cbu_pkg::*;
	logic is_branch;
	logic is_imm;
	logic delay;
	cbu_cmp_t cmp;
	logic [4:0] cmp_idx;
	logic [4:0] ofs_idx;
	logic [15:0] imm16;
	modport dec (output is_branch, output is_imm, output delay, output cmp, output cmp_idx, output ofs_idx,
		output imm16);
	modport use_side (input is_branch, input is_imm, input delay, input cmp, input cmp_idx, input ofs_idx,
		input imm16);
endinterface

// [verilog/cbu_decoder.sv]
/*
 * cbu_decoder: combinational field decode of one instruction word.
 * assumes the word is stable while instr_valid is high.
 */
`timescale 1ns/10ps
module cbu_decoder
	import cbu_pkg::*;
(
	// instruction
	input wire logic [31:0] instr,
	input wire logic instr_valid,
	// decoded fields
	cbu_dec_if.dec dec
);

	// ----------------------------------------
	// field decode
	// ----------------------------------------
	// msb-first numbering: field bit n is word bit 31-n
	function automatic logic [31:0] fld(input logic [31:0] w, input int hi, input int lo);
		fld = (w >> (31 - lo)) & ((32'h0000_0001 << (lo - hi + 1)) - 32'h0000_0001);
	endfunction

	logic [31:0] opc;
	logic [31:0] cnd;
	logic [31:0] tail;
	logic zero_tail;
	always_comb begin
		opc = fld(instr, OPC_HI, OPC_LO);
		cnd = fld(instr, COND_HI, COND_LO);
		tail = fld(instr, 21, 31);
		zero_tail = (tail == 32'h0000_0000);
	end

	always_comb begin
		dec.is_imm = (opc[5:0] == OPC_IMM);
		dec.delay = instr[31 - DLY_BIT];
		dec.cmp_idx = 5'(fld(instr, CMP_REG_HI, CMP_REG_LO));
		dec.ofs_idx = 5'(fld(instr, OFS_REG_HI, OFS_REG_LO));
		dec.imm16 = 16'(fld(instr, IMM_HI, IMM_LO));
		case (cnd[3:0])
			COND_GT: dec.cmp = CBU_CMP_GT;
			COND_LE: dec.cmp = CBU_CMP_LE;
			COND_LT: dec.cmp = CBU_CMP_LT;
			default: dec.cmp = CBU_CMP_NONE;
		endcase
		// less-than immediate and greater-than register are outside this unit; register form needs a zero tail
		dec.is_branch = instr_valid && (dec.cmp != CBU_CMP_NONE) &&
			((opc[5:0] == OPC_REG && zero_tail && dec.cmp != CBU_CMP_GT) ||
			(opc[5:0] == OPC_IMM && dec.cmp != CBU_CMP_LT));
	end

endmodule

// [verilog/cbu_branch_unit.sv]
/*
 * cbu_branch_unit: executes the greater-than, less-or-equal and less-than
 * conditional branches: condition test, target, delay slot and stall timing.
 * assumes register-read supplies both operand values in the issue cycle,
 * the predictor supplies a prediction, and the issuer holds off while busy.
 */
`timescale 1ns/10ps
module cbu_branch_unit
	import cbu_pkg::*;
#(
	parameter int AREA_OPTIMIZATION_LEVEL = 0
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// issue from decode
	input wire logic issue_valid,
	input wire logic [31:0] instr,
	input wire logic [31:0] pc,
	// register read
	output logic [4:0] compare_operand_reg,
	output logic [4:0] offset_operand_reg,
	input wire logic [31:0] compare_operand_val,
	input wire logic [31:0] offset_operand_val,
	// immediate prefix
	input wire logic prefix_valid,
	input wire logic [15:0] prefix_high,
	// prediction
	input wire logic pred_valid,
	input wire logic pred_taken,
	// event requests
	input wire logic irq_req,
	input wire logic brk_req,
	// results
	output logic branch_done,
	output logic branch_taken,
	output logic [31:0] next_pc_out,
	output logic squash_next,
	output logic mispredict,
	output logic busy,
	output logic in_slot,
	output logic irq_take,
	output logic brk_take
);

	cbu_dec_if dec_bus ();

	cbu_decoder u_dec (
		.instr(instr),
		.instr_valid(issue_valid),
		.dec(dec_bus.dec)
	);

	// ----------------------------------------
	// condition test
	// ----------------------------------------
	// the compare operand is always read as a signed value against zero
	function automatic logic cond_hold(input cbu_cmp_t c, input logic signed [31:0] v);
		case (c)
			CBU_CMP_GT: cond_hold = (v > 0);
			CBU_CMP_LE: cond_hold = (v <= 0);
			CBU_CMP_LT: cond_hold = (v < 0);
			default: cond_hold = 1'b0;
		endcase
	endfunction

	logic signed [31:0] opnd;
	logic cond_ok;
	logic go;
	logic misp;

	always_comb begin
		opnd = signed'(compare_operand_val);
		cond_ok = cond_hold(dec_bus.cmp, opnd);
		// only this group's encodings, and never while an earlier branch still stalls
		go = issue_valid && dec_bus.is_branch && !busy;
		// a prediction only exists for the immediate forms
		misp = dec_bus.is_imm && pred_valid && (pred_taken != cond_ok);
	end

	// ----------------------------------------
	// immediate operand and target
	// ----------------------------------------
	logic [31:0] imm_ext;
	logic [31:0] target;

	always_comb begin
		// a directly preceding prefix supplies the upper half instead of sign bits
		if (prefix_valid) begin
			imm_ext = {prefix_high, dec_bus.imm16};
		end else begin
			imm_ext = {{16{dec_bus.imm16[15]}}, dec_bus.imm16};
		end
		if (!cond_ok) begin
			target = pc + PC_STEP;
		end else if (dec_bus.is_imm) begin
			target = pc + imm_ext;
		end else begin
			target = pc + offset_operand_val;
		end
	end

	// ----------------------------------------
	// latency selection
	// ----------------------------------------
	int lat;

	always_comb begin
		if (dec_bus.is_imm && pred_valid) begin
			// a correct guess costs a single cycle whichever way it went
			if (!misp) begin
				lat = LAT_NOT_TAKEN;
			end else if (AREA_OPTIMIZATION_LEVEL == 2) begin
				// the area-lean build pays for its savings on every wrong guess
				lat = LAT_MISP_AREA2;
			end else begin
				lat = LAT_MISP_AREA0;
			end
		end else if (!cond_ok) begin
			lat = LAT_NOT_TAKEN;
		end else if (dec_bus.delay) begin
			lat = LAT_TAKEN_DLY;
		end else begin
			lat = LAT_TAKEN_NODLY;
		end
	end

	assign compare_operand_reg = dec_bus.cmp_idx;
	assign offset_operand_reg = dec_bus.ofs_idx;

	// ----------------------------------------
	// result registers
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			branch_done <= 1'b0;
			branch_taken <= 1'b0;
			squash_next <= 1'b0;
			mispredict <= 1'b0;
		end else begin
			branch_done <= go;
			branch_taken <= go && cond_ok;
			// without a slot the fetched follower of a taken branch never executes
			squash_next <= go && cond_ok && !dec_bus.delay;
			mispredict <= go && misp;
		end
	end

	// pc is the only architectural state a branch alters, so it holds between branches
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			next_pc_out <= PC_RESET;
		end else if (go) begin
			next_pc_out <= target;
		end
	end

	// ----------------------------------------
	// stall counter
	// ----------------------------------------
	logic [3:0] stall;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			stall <= STALL_RESET;
		end else if (go) begin
			stall <= 4'(lat - 1);
		end else if (stall != STALL_RESET) begin
			stall <= stall - 4'h1;
		end
	end

	// ----------------------------------------
	// delay slot tracking
	// ----------------------------------------
	// slot opens after any delayed branch, taken or not, and closes when the follower issues;
	// the issuer must keep prefix, branch and break out of it
	logic slot_pend;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			slot_pend <= 1'b0;
		end else if (go && dec_bus.delay) begin
			slot_pend <= 1'b1;
		end else if (slot_pend && issue_valid && !busy) begin
			slot_pend <= 1'b0;
		end
	end

	// ----------------------------------------
	// stall and slot status
	// ----------------------------------------
	assign busy = (stall != STALL_RESET);
	assign in_slot = slot_pend;

	// ----------------------------------------
	// event gating
	// ----------------------------------------
	logic evt_open;
	logic [1:0] evt_req;
	logic [1:0] evt_take;

	// hold events until branch and its slot instruction are both past
	assign evt_open = !busy && !slot_pend && !go;
	assign evt_req = {brk_req, irq_req};
	for (genvar g = 0; g < 2; g++) begin : g_evt
		assign evt_take[g] = evt_req[g] && evt_open;
	end
	assign irq_take = evt_take[0];
	assign brk_take = evt_take[1];

endmodule

// [dv/cbu_branch_unit_assertions.sv]
/* cbu_branch_unit_assertions: port-level checks of the branch unit.
   assumes the default area level, so a mispredict costs what a plain taken branch costs. */
`timescale 1ns/10ps
module cbu_chk
	import cbu_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// issue side
	input wire logic issue_valid,
	input wire logic [31:0] instr,
	input wire logic [31:0] pc,
	input wire logic [31:0] offset_operand_val,
	// results
	input wire logic branch_done,
	input wire logic branch_taken,
	input wire logic [31:0] next_pc_out,
	input wire logic squash_next,
	input wire logic mispredict,
	input wire logic busy,
	input wire logic in_slot,
	input wire logic irq_take,
	input wire logic brk_take
);
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	logic acc;
	// only the encodings of this group count as accepted branches
	assign acc = issue_valid && !busy && (instr[31:26] == OPC_REG ? instr[24:21] inside {COND_LE, COND_LT} &&
		instr[10:0] == 11'h000 : instr[31:26] == OPC_IMM && instr[24:21] inside {COND_GT, COND_LE});
	a_accept_done: assert property (acc |=> branch_done) else $error("no done");
	a_slot_set: assert property (acc && instr[25] |=> in_slot) else $error("no slot");
	a_slot_defer: assert property (in_slot |-> !irq_take && !brk_take) else $error("event in slot");
	a_squash_why: assert property (squash_next |-> branch_taken && !$past(instr[25])) else $error("bad squash");
	a_nodly_cost: assert property (squash_next |-> busy [*2] ##1 !busy) else $error("bad stall");
	a_fast_untaken: assert property (branch_done && !branch_taken && !mispredict |-> !busy) else $error("slow");
	a_misp_cost: assert property (mispredict |-> busy [*2] ##1 !busy) else $error("bad mispredict stall");
	a_fall_pc: assert property (branch_done && !branch_taken |-> next_pc_out == $past(pc) + PC_STEP)
		else $error("bad fall pc");
	a_reg_pc: assert property (branch_taken && $past(instr[31:26]) == OPC_REG |->
		next_pc_out == $past(pc) + $past(offset_operand_val)) else $error("bad target");
endmodule
bind cbu_branch_unit cbu_chk i_chk (.clk_sys, .arst_n, .issue_valid, .instr, .pc, .offset_operand_val,
	.branch_done, .branch_taken, .next_pc_out, .squash_next, .mispredict, .busy, .in_slot, .irq_take, .brk_take);

// [dv/cbu_regfile.sv]
/* cbu_regfile: register-read stage answering operand reads in the issue cycle.
   assumes indices are held stable while the branch is presented. */
`timescale 1ns/10ps
module cbu_regfile
	import cbu_pkg::*;
(
	// indices
	input wire logic [4:0] compare_operand_reg,
	input wire logic [4:0] offset_operand_reg,
	// values
	output logic [31:0] compare_operand_val,
	output logic [31:0] offset_operand_val
);
	// fixed contents: positive, zero, negative operands and one offset
	function automatic logic [31:0] rd(input logic [4:0] i);
		case (i)
			5'h01: return 32'h0000_0005;
			5'h03: return 32'hffff_ffff;
			5'h04: return 32'h0000_0100;
			default: return 32'h0000_0000;
		endcase
	endfunction
	assign compare_operand_val = rd(compare_operand_reg);
	assign offset_operand_val = rd(offset_operand_reg);
endmodule

// [dv/cbu_branch_unit_tb.sv]
/* cbu_branch_unit_tb: directed checks of the conditional branch unit.
   assumes the default area level; pc stays at one address so targets are easy to work out. */
`timescale 1ns/10ps
module cbu_branch_unit_tb
	import cbu_pkg::*;
;
	logic clk_sys = 0;
	logic arst_n = 0;
	logic issue_valid = 0;
	logic [31:0] instr = 0;
	logic [31:0] pc = 32'h0000_1000;
	logic prefix_valid = 0;
	logic [15:0] prefix_high = 0;
	logic pred_valid = 0;
	logic pred_taken = 0;
	logic irq_req = 1;
	logic brk_req = 1;
	logic [4:0] compare_operand_reg, offset_operand_reg;
	logic [31:0] compare_operand_val, offset_operand_val, next_pc_out;
	logic branch_done, branch_taken, squash_next, mispredict, busy, in_slot, irq_take, brk_take;
	int miscompares = 0;
	int tests_run = 0;
	cbu_branch_unit i_dut (.clk_sys, .arst_n, .issue_valid, .instr, .pc, .compare_operand_reg, .offset_operand_reg,
		.compare_operand_val, .offset_operand_val, .prefix_valid, .prefix_high, .pred_valid, .pred_taken,
		.irq_req, .brk_req, .branch_done, .branch_taken, .next_pc_out, .squash_next, .mispredict, .busy,
		.in_slot, .irq_take, .brk_take);
	cbu_regfile i_rf (.compare_operand_reg, .offset_operand_reg, .compare_operand_val, .offset_operand_val);
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	function automatic logic [31:0] rw(input logic d, input logic [3:0] c, input logic [4:0] a);
		return {OPC_REG, d, c, a, 5'h04, 11'h000};
	endfunction
	function automatic logic [31:0] iw(input logic d, input logic [3:0] c, input logic [4:0] a, input logic [15:0] m);
		return {OPC_IMM, d, c, a, m};
	endfunction
	task automatic put(input logic [31:0] w);
		@(posedge clk_sys);
		issue_valid <= 1;
		instr <= w;
		@(posedge clk_sys);
		issue_valid <= 0;
		#1;
	endtask
	task automatic br(input logic [31:0] w, input logic t, input logic [31:0] npc, input int lat, input logic m);
		int n;
		n = 1;
		put(w);
		chk(branch_done, 1);
		chk(branch_taken, t);
		chk(next_pc_out, npc);
		chk(squash_next, t & ~w[25]);
		chk(mispredict, m);
		while (busy === 1 && n < 12) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk(n, lat);
		if (n == 12) end_of_test;
		if (w[25]) begin
			chk(in_slot, 1);
			chk({irq_take, brk_take}, 0);
			put(32'h0000_0000);
			chk({irq_take, brk_take}, 2'h3);
		end
	endtask
	task automatic t_gt;
		br(iw(0, COND_GT, 5'h01, 16'hfff0), 1, 32'h0000_0ff0, LAT_TAKEN_NODLY, 0);
		br(iw(0, COND_GT, 5'h02, 16'h0040), 0, 32'h0000_1004, LAT_NOT_TAKEN, 0);
		br(iw(1, COND_GT, 5'h03, 16'h0040), 0, 32'h0000_1004, LAT_NOT_TAKEN, 0);
		$display("t_gt done");
	endtask
	task automatic t_le;
		br(rw(0, COND_LE, 5'h02), 1, 32'h0000_1100, LAT_TAKEN_NODLY, 0);
		br(rw(0, COND_LE, 5'h01), 0, 32'h0000_1004, LAT_NOT_TAKEN, 0);
		br(iw(1, COND_LE, 5'h03, 16'h0008), 1, 32'h0000_1008, LAT_TAKEN_DLY, 0);
		$display("t_le done");
	endtask
	task automatic t_lt;
		br(rw(1, COND_LT, 5'h03), 1, 32'h0000_1100, LAT_TAKEN_DLY, 0);
		br(rw(0, COND_LT, 5'h02), 0, 32'h0000_1004, LAT_NOT_TAKEN, 0);
		$display("t_lt done");
	endtask
	task automatic t_misc;
		@(posedge clk_sys);
		prefix_valid <= 1;
		prefix_high <= 16'h0001;
		br(iw(0, COND_GT, 5'h01, 16'h8010), 1, 32'h0001_9010, LAT_TAKEN_NODLY, 0);
		@(posedge clk_sys);
		prefix_valid <= 0;
		pred_valid <= 1;
		br(iw(0, COND_GT, 5'h01, 16'h0020), 1, 32'h0000_1020, LAT_MISP_AREA0, 1);
		// a correct not-taken guess keeps the single-cycle cost
		br(iw(0, COND_GT, 5'h02, 16'h0040), 0, 32'h0000_1004, LAT_NOT_TAKEN, 0);
		@(posedge clk_sys);
		pred_valid <= 0;
		put(iw(0, COND_LT, 5'h03, 16'h0010));
		chk(branch_done, 0);
		put(rw(0, COND_LT, 5'h03) | 32'h0000_0001);
		chk(branch_done, 0);
		put(rw(0, COND_GT, 5'h01));
		chk(branch_done, 0);
		$display("t_misc done");
	endtask
	task automatic t_rst;
		// leave a slot open and a pc behind, then reset in mid-run
		put(iw(1, COND_GT, 5'h03, 16'h0040));
		@(posedge clk_sys);
		arst_n <= 0;
		@(posedge clk_sys);
		#1;
		chk(next_pc_out, PC_RESET);
		chk({branch_done, in_slot, busy}, 0);
		@(posedge clk_sys);
		arst_n <= 1;
		br(rw(0, COND_LE, 5'h02), 1, 32'h0000_1100, LAT_TAKEN_NODLY, 0);
		$display("t_rst done");
	endtask
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		arst_n <= 1;
		t_gt;
		t_le;
		t_lt;
		t_misc;
		t_rst;
		end_of_test;
	end
endmodule
